// >>> design/edge_sync.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // asynchronous input
  input  wire logic async_i,
  // edge pulses, one bus cycle each
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // first flop feeds only the second one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;

endmodule
`default_nettype wire

// >>> design/modulo_timer_8bit.sv
// modulo timer top: wishbone slave, clock source select, prescaler, counter and interrupt
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module modulo_timer_8bit (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // clock inputs from outside the bus clock domain
  input  wire logic        ext_timer_clock_pin_i,
  input  wire logic        fixed_freq_clock_i,
  // power and debug modes, bus clock domain
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic        stop_wake_reset_i,
  input  wire logic        debug_active_i,
  // interrupt
  output logic             irq_o
);

  // *****************************************************************
  // declarations
  // *****************************************************************
  logic       ovf_flag_reg;
  logic       ovf_mask_reg;
  logic       counter_halt_bit_reg;
  logic [1:0] src_sel_reg;
  logic [3:0] ps_sel_reg;
  logic [7:0] count_reg;
  logic [7:0] modulo_limit_register_reg;
  logic       ack_reg;
  logic [31:0] rdata_reg;
  logic       irq_reg;

  logic       timer_rst;
  logic       access;
  logic       wr_en;
  logic       rd_en;
  logic       wr_byte0;
  logic [7:0] wbyte;
  logic       soft_clear;
  logic       pin_rise;
  logic       pin_fall;
  logic       fixed_rise;
  logic       src_pulse;
  logic       run;
  logic       presc_tick;
  logic [7:0] limit;
  logic       ovf_event;
  logic [3:0] ps_eff;
  logic [31:0] rdata_next;

  // *****************************************************************
  // reset sources
  // *****************************************************************
  // wake from deepest/deep stop, or shallow stop left by reset
  assign timer_rst = rst_i | stop_wake_reset_i;

  // *****************************************************************
  // bus decode
  // *****************************************************************
  // single-cycle answer: request taken on the edge where ack rises
  assign access   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_en    = access & wb_we_i;
  assign rd_en    = access & ~wb_we_i;
  assign wr_byte0 = wr_en & wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];

  // counter reset bit written to one, or modulo register written
  assign soft_clear = wr_byte0 &
                      (((wb_adr_i == modulo_timer_pkg::ADDR_CONTROL) &&
                        wbyte[modulo_timer_pkg::CTRL_RESET_BIT]) ||
                       (wb_adr_i == modulo_timer_pkg::ADDR_MODULO));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  assign wb_ack_o = ack_reg;

  // *****************************************************************
  // clock source selection
  // *****************************************************************
  // pin edges only after two flops; pin must run below a quarter of clk
  edge_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ext_timer_clock_pin_i),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  edge_sync u_fixed_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (fixed_freq_clock_i),
    .rise_o  (fixed_rise),
    .fall_o  ()
  );

  always_comb begin
    src_pulse = 1'b0;
    unique case (modulo_timer_pkg::clk_source_e'(src_sel_reg))
      modulo_timer_pkg::SRC_BUS:      src_pulse = 1'b1;
      modulo_timer_pkg::SRC_FIXED:    src_pulse = fixed_rise;
      modulo_timer_pkg::SRC_PIN_RISE: src_pulse = pin_rise;
      modulo_timer_pkg::SRC_PIN_FALL: src_pulse = pin_fall;
    endcase
  end

  // *****************************************************************
  // run gating
  // *****************************************************************
  // wait mode does not gate: an enabled timer keeps counting
  // stop and debug gate only the prescaler step so counting resumes in place
  assign run = ~counter_halt_bit_reg & ~stop_mode_i & ~debug_active_i;

  // *****************************************************************
  // prescaler
  // *****************************************************************
  // select codes above the largest factor saturate at divide by 256
  assign ps_eff = (ps_sel_reg > modulo_timer_pkg::PS_MAX) ? modulo_timer_pkg::PS_MAX : ps_sel_reg;

  pow2_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .clk_i  (clk_i),
    .rst_i  (timer_rst),
    .clr_i  (soft_clear),
    .step_i (src_pulse & run),
    .sel_i  (ps_eff),
    .tick_o (presc_tick)
  );

  // *****************************************************************
  // counter
  // *****************************************************************
  // zero modulo means the counter wraps at its full range
  assign limit     = (modulo_limit_register_reg == 8'h00) ? modulo_timer_pkg::COUNT_FULL
                                                          : modulo_limit_register_reg;
  assign ovf_event = presc_tick & (count_reg == limit);

  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      count_reg <= modulo_timer_pkg::COUNT_RESET;
    end else if (soft_clear) begin
      count_reg <= modulo_timer_pkg::COUNT_RESET;
    end else if (presc_tick) begin
      if (count_reg == limit) begin
        count_reg <= 8'h00;
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

  // *****************************************************************
  // control registers
  // *****************************************************************
  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      counter_halt_bit_reg <= modulo_timer_pkg::HALT_RESET;
    end else if (wr_byte0 && (wb_adr_i == modulo_timer_pkg::ADDR_CONTROL)) begin
      counter_halt_bit_reg <= wbyte[modulo_timer_pkg::CTRL_HALT_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      src_sel_reg <= 2'h0;
      ps_sel_reg  <= modulo_timer_pkg::PS_RESET;
    end else if (wr_byte0 && (wb_adr_i == modulo_timer_pkg::ADDR_CLKCFG)) begin
      src_sel_reg <= wbyte[modulo_timer_pkg::CLKCFG_SRC_LSB +: 2];
      ps_sel_reg  <= wbyte[modulo_timer_pkg::CLKCFG_PS_LSB +: 4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      modulo_limit_register_reg <= modulo_timer_pkg::MODULO_RESET;
    end else if (wr_byte0 && (wb_adr_i == modulo_timer_pkg::ADDR_MODULO)) begin
      modulo_limit_register_reg <= wbyte;
    end
  end

  // *****************************************************************
  // interrupt status and mask
  // *****************************************************************
  // a new overflow wins over a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_event) begin
      ovf_flag_reg <= 1'b1;
    end else if (wr_byte0 && (wb_adr_i == modulo_timer_pkg::ADDR_STATUS) &&
                 wbyte[modulo_timer_pkg::STATUS_OVF_BIT]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      ovf_mask_reg <= 1'b0;
    end else if (wr_byte0 && (wb_adr_i == modulo_timer_pkg::ADDR_MASK)) begin
      ovf_mask_reg <= wbyte[modulo_timer_pkg::STATUS_OVF_BIT];
    end
  end

  // the flag cannot set in stop; the request rises there only from a flag already set before stop
  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ovf_flag_reg & ovf_mask_reg;
    end
  end

  assign irq_o = irq_reg;

  // *****************************************************************
  // read mux
  // *****************************************************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (wb_adr_i)
      modulo_timer_pkg::ADDR_STATUS: begin
        rdata_next[modulo_timer_pkg::STATUS_OVF_BIT] = ovf_flag_reg;
      end
      modulo_timer_pkg::ADDR_MASK: begin
        rdata_next[modulo_timer_pkg::STATUS_OVF_BIT] = ovf_mask_reg;
      end
      modulo_timer_pkg::ADDR_CONTROL: begin
        // reset bit always reads zero
        rdata_next[modulo_timer_pkg::CTRL_HALT_BIT] = counter_halt_bit_reg;
      end
      modulo_timer_pkg::ADDR_CLKCFG: begin
        rdata_next[modulo_timer_pkg::CLKCFG_SRC_LSB +: 2] = src_sel_reg;
        rdata_next[modulo_timer_pkg::CLKCFG_PS_LSB +: 4]  = ps_sel_reg;
      end
      modulo_timer_pkg::ADDR_COUNT: begin
        rdata_next[7:0] = count_reg;
      end
      modulo_timer_pkg::ADDR_MODULO: begin
        rdata_next[7:0] = modulo_limit_register_reg;
      end
      modulo_timer_pkg::ADDR_STATE: begin
        rdata_next[modulo_timer_pkg::STATE_ACTIVE_BIT] = run;
        rdata_next[modulo_timer_pkg::STATE_WAIT_BIT]   = wait_mode_i;
        rdata_next[modulo_timer_pkg::STATE_STOP_BIT]   = stop_mode_i;
        rdata_next[modulo_timer_pkg::STATE_DEBUG_BIT]  = debug_active_i;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign wb_dat_o = rdata_reg;

endmodule
`default_nettype wire

// >>> design/modulo_timer_pkg.sv
// package: register map, field layout, reset values and timing constants of the modulo timer
//
// Function
// - 8-bit up-counter runs free or counts to a programmable 8-bit modulo limit.
// - overflow raises an interrupt request only when software has enabled it.
// - writing one to the counter-reset bit clears counter and prescaler.
// - counter-halt bit stops counting while set; counting runs while clear.
// - prescaler source: bus clock, fixed clock, ext pin rising or falling edge.
// - prescaler divides the source by a power of two from 1 to 256.
// - an enabled timer keeps counting in wait mode so overflow can end wait.
// - every stop mode disables the timer; it never wakes the system from stop.
// - waking from the deepest or deep stop mode puts the timer in reset state.
// - leaving shallow stop through a reset puts the timer in reset state.
// - leaving shallow stop by interrupt keeps state; counting resumes from held value.
// - background debug suspends counting; resumes unless counter reset or modulo written.
// - external clock pin is synchronised to the bus clock before edges are used.
package modulo_timer_pkg;

  // *****************************************************************
  // register byte addresses
  // *****************************************************************
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CLKCFG  = 8'h0c;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_MODULO  = 8'h14;
  localparam logic [7:0] ADDR_STATE   = 8'h18;

  // *****************************************************************
  // field positions
  // *****************************************************************
  localparam int STATUS_OVF_BIT   = 0;
  localparam int CTRL_HALT_BIT    = 4;
  localparam int CTRL_RESET_BIT   = 5;
  localparam int CLKCFG_PS_LSB    = 0;
  localparam int CLKCFG_SRC_LSB   = 4;
  localparam int STATE_ACTIVE_BIT = 0;
  localparam int STATE_WAIT_BIT   = 1;
  localparam int STATE_STOP_BIT   = 2;
  localparam int STATE_DEBUG_BIT  = 3;

  // *****************************************************************
  // reset values, largest prescaler select and full-range count
  // *****************************************************************
  localparam logic       HALT_RESET     = 1'b1;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] MODULO_RESET   = 8'h00;
  localparam logic [3:0] PS_RESET       = 4'h0;
  localparam logic [3:0] PS_MAX         = 4'h8;
  localparam logic [7:0] COUNT_FULL     = 8'hff;

  // prescaler input source encoding
  typedef enum logic [1:0] {
    SRC_BUS,
    SRC_FIXED,
    SRC_PIN_RISE,
    SRC_PIN_FALL
  } clk_source_e;

  // *****************************************************************
  // timing
  // *****************************************************************
  localparam int CLK_FREQ_HZ     = 50_000_000;
  localparam int PIN_DIV_MIN     = 4;
  localparam int PIN_MAX_FREQ_HZ = CLK_FREQ_HZ / PIN_DIV_MIN;

endpackage

// >>> design/pow2_prescaler.sv
// power-of-two prescaler: one tick every 2**sel steps
`timescale 1ns/100ps
`default_nettype none
module pow2_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       clr_i,
  input  wire logic       step_i,
  input  wire logic [3:0] sel_i,
  // divided tick
  output logic            tick_o
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] last_val;

  // last value before wrap is 2**sel - 1
  assign last_val = WIDTH'((1 << sel_i) - 1);
  assign tick_o   = step_i & (count_reg == last_val);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      count_reg <= '0;
    end else if (step_i) begin
      if (count_reg == last_val) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + WIDTH'(1);
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/ext_clk_src.sv
// model of an outside clock source driving a timer clock pin
`timescale 1ns/100ps
`default_nettype none
module ext_clk_src (
  // control
  input  wire logic en_i,
  input  var  int   half_i,
  // pin and edge counts
  output logic      pin_o,
  output int        rise_n_o,
  output int        fall_n_o
);
  initial begin
    pin_o = 1'b0;
    rise_n_o = 0;
    fall_n_o = 0;
    forever begin
      wait (en_i);
      // half period of 40 ns or more keeps the pin at or below a quarter of the bus rate
      #(half_i);
      // runs only in bursts; holds its level between them
      if (en_i) begin
        pin_o = ~pin_o;
        if (pin_o) rise_n_o++;
        else fall_n_o++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/modulo_timer_8bit_chk.sv
// checker: port-level properties of the modulo timer, bound to its top
`timescale 1ns/100ps
`default_nettype none
module modulo_timer_8bit_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins, modes and interrupt
  input wire logic        ext_timer_clock_pin_i,
  input wire logic        fixed_freq_clock_i,
  input wire logic        wait_mode_i,
  input wire logic        stop_mode_i,
  input wire logic        stop_wake_reset_i,
  input wire logic        debug_active_i,
  input wire logic        irq_o
);
  logic       mask_sh;
  logic [7:0] mod_sh;
  logic       rd;
  logic       wr;

  assign rd = wb_ack_o && !wb_we_i;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // shadows of writable controls; wake reset clears them like the timer
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_wake_reset_i) begin
      mask_sh <= 1'b0;
    end else if (wr && wb_adr_i == modulo_timer_pkg::ADDR_MASK) begin
      mask_sh <= wb_dat_i[0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_wake_reset_i) begin
      mod_sh <= 8'h00;
    end else if (wr && wb_adr_i == modulo_timer_pkg::ADDR_MODULO) begin
      mod_sh <= wb_dat_i[7:0];
    end
  end

  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_idle;
    $fell(rst_i) |-> !irq_o && !wb_ack_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("irq or ack after reset");

  property p_wake_idle;
    stop_wake_reset_i |-> ##2 !irq_o;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("irq after wake reset");

  property p_irq_mask;
    irq_o |-> $past(mask_sh);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

  property p_dat_upper;
    rd |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("read data above 8 bits");

  property p_clr_reads0;
    rd && wb_adr_i == modulo_timer_pkg::ADDR_CONTROL |-> !wb_dat_o[modulo_timer_pkg::CTRL_RESET_BIT];
  endproperty
  a_clr_reads0: assert property (p_clr_reads0) else $error("counter reset bit reads one");

  property p_cnt_limit;
    rd && wb_adr_i == modulo_timer_pkg::ADDR_COUNT && mod_sh != 8'h00 |-> wb_dat_o[7:0] <= mod_sh;
  endproperty
  a_cnt_limit: assert property (p_cnt_limit) else $error("count above modulo");

  property p_stop_state;
    rd && wb_adr_i == modulo_timer_pkg::ADDR_STATE && $past(stop_mode_i) && $past(stop_mode_i, 2)
      |-> wb_dat_o[modulo_timer_pkg::STATE_STOP_BIT] && !wb_dat_o[modulo_timer_pkg::STATE_ACTIVE_BIT];
  endproperty
  a_stop_state: assert property (p_stop_state) else $error("running in stop");

  property p_dbg_state;
    rd && wb_adr_i == modulo_timer_pkg::ADDR_STATE && $past(debug_active_i) && $past(debug_active_i, 2)
      |-> wb_dat_o[modulo_timer_pkg::STATE_DEBUG_BIT] && !wb_dat_o[modulo_timer_pkg::STATE_ACTIVE_BIT];
  endproperty
  a_dbg_state: assert property (p_dbg_state) else $error("running in debug");

  c_irq: cover property ($rose(irq_o));
  c_wake: cover property (stop_wake_reset_i);
  c_stop_rd: cover property (rd && stop_mode_i);
endmodule

bind modulo_timer_8bit modulo_timer_8bit_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_timer_clock_pin_i(ext_timer_clock_pin_i),
  .fixed_freq_clock_i(fixed_freq_clock_i), .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
  .stop_wake_reset_i(stop_wake_reset_i), .debug_active_i(debug_active_i), .irq_o(irq_o));
`default_nettype wire

// >>> testbench/modulo_timer_8bit_tb_top.sv
// self-checking bench for the modulo timer
`timescale 1ns/100ps
`default_nettype none
module modulo_timer_8bit_tb_top;
  localparam logic [7:0] A_ST = modulo_timer_pkg::ADDR_STATUS;
  localparam logic [7:0] A_MK = modulo_timer_pkg::ADDR_MASK;
  localparam logic [7:0] A_CT = modulo_timer_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_CF = modulo_timer_pkg::ADDR_CLKCFG;
  localparam logic [7:0] A_CN = modulo_timer_pkg::ADDR_COUNT;
  localparam logic [7:0] A_MD = modulo_timer_pkg::ADDR_MODULO;
  localparam logic [7:0] A_SE = modulo_timer_pkg::ADDR_STATE;
  localparam logic [7:0] HLT  = 8'h01 << modulo_timer_pkg::CTRL_HALT_BIT;
  localparam logic [7:0] CLR  = 8'h01 << modulo_timer_pkg::CTRL_RESET_BIT;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic        pin;
  logic        fix;
  logic        pin_en;
  logic        fix_en;
  logic        wait_m;
  logic        stop_m;
  logic        wake;
  logic        dbg;
  int          half;
  int          rise_n;
  int          fall_n;
  int          fix_n;
  int          err_count = 0;
  int          checks = 0;
  int          cyc_n = 0;

  modulo_timer_8bit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_timer_clock_pin_i(pin), .fixed_freq_clock_i(fix), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
    .stop_wake_reset_i(wake), .debug_active_i(dbg), .irq_o(irq));
  ext_clk_src p_pin (.en_i(pin_en), .half_i(half), .pin_o(pin), .rise_n_o(rise_n), .fall_n_o(fall_n));
  ext_clk_src p_fix (.en_i(fix_en), .half_i(61), .pin_o(fix), .rise_n_o(fix_n), .fall_n_o());

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits up to 100 cycles for ack, then counts a mismatch
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rdat = dat_o;
    cyc <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask

  function automatic int cnt(input int k);
    return (k == 2) ? fix_n : (k == 1) ? fall_n : rise_n;
  endfunction

  function automatic logic [7:0] cfg(input int k, input int ps);
    logic [1:0] s;
    s = (k == 2) ? modulo_timer_pkg::SRC_FIXED : 2'(k + 2);
    return {2'b00, s, 4'(ps)};
  endfunction

  // n edges of kind k: 0 pin rise, 1 pin fall, 2 fixed rise; then let sync settle
  task automatic pulse(input int k, input int n);
    int base;
    int t;
    base = cnt(k);
    t = 0;
    if (k == 2) fix_en <= 1'b1;
    else pin_en <= 1'b1;
    while (cnt(k) < base + n && t < 20000) begin
      @(posedge clk_i);
      t++;
    end
    pin_en <= 1'b0;
    fix_en <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(A_CT, HLT);
    rd(A_ST, 8'h00);
    rd(A_MK, 8'h00);
    rd(A_CF, 8'h00);
    rd(8'h1c, 8'h00);
    repeat (30) @(posedge clk_i);
    rd(A_CN, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_bus_irq();
    bus(1'b1, A_MD, 8'h04);
    bus(1'b1, A_CT, 8'h00);
    repeat (20) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    rd(A_ST, 8'h01);
    bus(1'b1, A_MK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    bus(1'b1, A_CT, HLT);
    bus(1'b1, A_ST, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    rd(A_ST, 8'h00);
    $display("t_bus_irq done");
  endtask

  // every prescale factor, sources rotating; three ticks each
  task automatic t_presc();
    for (int n = 0; n < 9; n++) begin
      bus(1'b1, A_CF, cfg(n % 3, n));
      bus(1'b1, A_CT, CLR);
      pulse(n % 3, 3 << n);
      rd(A_CN, 8'h03);
    end
    $display("t_presc done");
  endtask

  task automatic t_wrap();
    bus(1'b1, A_CF, cfg(0, 0));
    bus(1'b1, A_MD, 8'h05);
    bus(1'b1, A_ST, 8'h01);
    pulse(0, 5);
    rd(A_CN, 8'h05);
    rd(A_ST, 8'h00);
    pulse(0, 1);
    rd(A_CN, 8'h00);
    rd(A_ST, 8'h01);
    chk(32'(irq), 32'h1);
    bus(1'b1, A_MD, 8'h00);
    pulse(0, 255);
    rd(A_CN, 8'hff);
    pulse(0, 1);
    rd(A_CN, 8'h00);
    $display("t_wrap done");
  endtask

  task automatic t_modes();
    half = 137;
    bus(1'b1, A_CT, HLT | CLR);
    pulse(0, 4);
    rd(A_CN, 8'h00);
    bus(1'b1, A_CT, 8'h00);
    stop_m <= 1'b1;
    pulse(0, 4);
    rd(A_SE, 8'h01 << modulo_timer_pkg::STATE_STOP_BIT);
    rd(A_CN, 8'h00);
    stop_m <= 1'b0;
    pulse(0, 3);
    rd(A_CN, 8'h03);
    dbg <= 1'b1;
    pulse(0, 4);
    rd(A_SE, 8'h01 << modulo_timer_pkg::STATE_DEBUG_BIT);
    dbg <= 1'b0;
    pulse(0, 2);
    rd(A_CN, 8'h05);
    // a timer not needed in wait is halted first and must not count there
    bus(1'b1, A_CT, HLT);
    wait_m <= 1'b1;
    pulse(0, 2);
    rd(A_CN, 8'h05);
    rd(A_SE, 8'h01 << modulo_timer_pkg::STATE_WAIT_BIT);
    bus(1'b1, A_CT, 8'h00);
    pulse(0, 2);
    rd(A_CN, 8'h07);
    rd(A_SE, 8'h03);
    wait_m <= 1'b0;
    dbg <= 1'b1;
    bus(1'b1, A_MD, 8'h00);
    dbg <= 1'b0;
    pulse(0, 1);
    rd(A_CN, 8'h01);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    rd(A_CT, HLT);
    rd(A_CN, 8'h00);
    rd(A_MK, 8'h00);
    $display("t_modes done");
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    pin_en = 1'b0;
    fix_en = 1'b0;
    wait_m = 1'b0;
    stop_m = 1'b0;
    wake = 1'b0;
    dbg = 1'b0;
    half = 43;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bus_irq();
    t_presc();
    t_wrap();
    t_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
